// *** design/ctxe_writer.sv ***
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Event buffer between protocol engine and record writer
module ctxe_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    $error("ctxe_fifo: DEPTH must be a power of two of at least 2");

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          push;
  logic          pop;

  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign out_data = mem[rptr_r];

  // Fill count; flags are registered so ready never loops back
  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) cnt_nxt = cnt_r + CW'(1);
    if (pop && !push) cnt_nxt = cnt_r - CW'(1);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wptr_r    <= '0;
      rptr_r    <= '0;
      cnt_r     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else if (ce) begin
      if (push) wptr_r <= wptr_r + AW'(1);
      if (pop)  rptr_r <= rptr_r + AW'(1);
      cnt_r     <= cnt_nxt;
      in_ready  <= (cnt_nxt != CW'(DEPTH));
      out_valid <= (cnt_nxt != '0);
    end
  end

  // Storage has no reset; only entries below the count are read
  always_ff @(posedge ref_clk) begin
    if (ce && push) mem[wptr_r] <= in_data;
  end
endmodule : ctxe_fifo

// ============================================================
// Tx event record writer with standard filter list scanner
module ctxe_writer #(
  parameter int RAM_AW    = 16,
  parameter int EVT_MAX   = 32,
  parameter int BUF_DEPTH = 8
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [31:0]                reg_rdata,
  input  wire logic                  tx_sof,
  input  wire logic [15:0]           stamp_value,
  input  wire logic                  tx_done,
  input  wire ctxe_pkg::ctxe_evt_type tx_evt,
  output logic                       tx_evt_ready,
  input  wire logic                  scan_start,
  input  wire logic [10:0]           scan_id,
  output logic                       scan_done,
  output logic                       scan_hit,
  output logic [6:0]                 scan_index,
  output logic [2:0]                 scan_action,
  output logic [RAM_AW-1:0]          ram_addr,
  output logic [31:0]                ram_wdata,
  output logic                       ram_we,
  output logic                       ram_re,
  input  wire logic [31:0]           ram_rdata
);
  import ctxe_pkg::*;

  localparam int RW = $bits(ctxe_rec_type);

  if (EVT_MAX < 1 || EVT_MAX > 32 || RAM_AW < 8 || RAM_AW > 16)
    $error("ctxe_writer: EVT_MAX 1..32 and RAM_AW 8..16 only");

  typedef enum logic [1:0] {WR_IDLE, WR_WORD1, WR_COMMIT} ctxe_wst_type;
  typedef enum logic [1:0] {SC_IDLE, SC_READ, SC_WAIT, SC_EVAL}
    ctxe_sst_type;

  // ==========================================================
  // Record encoding and filter decoding
  function automatic logic [31:0] word0(input ctxe_rec_type r);
    logic [31:0] w;
    w = '0;
    w[W0_ESI_BIT] = r.evt.err_passive;
    w[W0_XTD_BIT] = r.evt.extended_id_flag;
    w[W0_RTR_BIT] = r.evt.remote_request_flag;
    if (r.evt.extended_id_flag) w[28:0] = r.evt.id;
    else w[28:STD_ID_LSB] = r.evt.id[10:0];
    return w;
  endfunction : word0

  function automatic logic [31:0] word1(input ctxe_rec_type r,
                                        input logic no_rt);
    logic [31:0] w;
    w = '0;
    w[W1_TAG_LSB +: 8] = r.evt.tag;
    w[W1_KIND_LSB +: 2] = (no_rt || r.evt.cancel) ?
                          KIND_CANCEL : KIND_TX;
    w[W1_FD_BIT]  = r.evt.fd;
    w[W1_BRS_BIT] = r.evt.rate_switch_flag;
    w[W1_DLC_LSB +: 4] = r.evt.dlc;
    w[15:0] = r.stamp;
    return w;
  endfunction : word1

  function automatic ctxe_flt_type flt_dec(input logic [31:0] e);
    ctxe_flt_type f;
    f.ftype  = e[31:30];
    f.action = e[29:27];
    f.id_a   = e[26:16];
    f.id_b   = e[10:0];
    return f;
  endfunction : flt_dec

  // Enabled element matching the id; a dedicated-buffer entry ignores type
  function automatic logic flt_hit(input ctxe_flt_type f,
                                   input logic [10:0] id);
    logic m;
    m = 1'b0;
    case (f.ftype)
      FT_RANGE:   m = (id >= f.id_a) && (id <= f.id_b);
      FT_DUAL:    m = (id == f.id_a) || (id == f.id_b);
      FT_CLASSIC: m = ((id ^ f.id_a) & f.id_b) == 11'h000;
      default:    m = 1'b0;
    endcase
    if (f.action == FA_DEDIC) m = (id == f.id_a);
    return m && (f.action != FA_OFF);
  endfunction : flt_hit

  // ==========================================================
  // Configuration registers
  logic [RAM_AW-1:0] evt_base_r;
  logic [5:0]        evt_size_r;
  logic [RAM_AW-1:0] flt_base_r;
  logic [7:0]        flt_size_r;
  logic              no_rt_r;
  logic              wr_cfg;

  assign wr_cfg = ce && reg_wr;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      evt_base_r <= '0;
      evt_size_r <= '0;
      flt_base_r <= '0;
      flt_size_r <= '0;
      no_rt_r    <= 1'b0;
    end else if (wr_cfg) begin
      case (reg_addr)
        REG_EVT_CFG: begin
          evt_base_r <= reg_wdata[RAM_AW-1:0];
          evt_size_r <= reg_wdata[EVT_SIZE_LSB +: 6];
        end
        REG_FLT_CFG: begin
          flt_base_r <= reg_wdata[RAM_AW-1:0];
          flt_size_r <= reg_wdata[FLT_SIZE_LSB +: 8];
        end
        REG_CTRL: no_rt_r <= reg_wdata[CTRL_NORT_BIT];
        default: ;
      endcase
    end
  end

  // Ring depth limited to what the indices can hold
  logic [5:0] ring_len;
  logic [7:0] flt_len;
  assign ring_len = (evt_size_r > 6'(EVT_MAX)) ? 6'(EVT_MAX) : evt_size_r;
  assign flt_len  = (flt_size_r > 8'(FLT_MAX)) ? 8'(FLT_MAX)
                                               : flt_size_r;

  // ==========================================================
  // Stamp capture and event buffer
  logic [15:0]  stamp_r;
  ctxe_rec_type in_rec;
  ctxe_rec_type cur;
  logic         buf_valid;
  logic         buf_ready;
  logic         wr_go;
  logic         drop_r;

  // Stamp latched at start of frame, paired with that frame's report
  always_ff @(posedge ref_clk) begin
    if (!rst_n) stamp_r <= '0;
    else if (ce && tx_sof) stamp_r <= stamp_value;
  end

  assign in_rec.evt   = tx_evt;
  assign in_rec.stamp = stamp_r;

  // One FIFO keeps records strictly in completion order
  ctxe_fifo #(.W(RW), .DEPTH(BUF_DEPTH)) u_buf (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_valid  (tx_done),
    .in_ready  (buf_ready),
    .in_data   (in_rec),
    .out_valid (buf_valid),
    .out_ready (wr_go),
    .out_data  (cur)
  );

  assign tx_evt_ready = buf_ready;

  // ==========================================================
  // Record writer and ring indices
  ctxe_wst_type      wst_r;
  ctxe_rec_type      hold_r;
  logic [4:0]        put_r;
  logic [4:0]        get_r;
  logic [5:0]        fill_r;
  logic              ack;
  logic              commit;
  logic              ring_room;

  assign ring_room = (ring_len != '0) && (fill_r < ring_len);
  assign wr_go  = ce && (wst_r == WR_IDLE) && buf_valid && ring_room;
  assign commit = ce && (wst_r == WR_COMMIT);
  assign ack    = wr_cfg && (reg_addr == REG_EVT_ACK) &&
                  reg_wdata[ACK_BIT] && (fill_r != '0);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wst_r  <= WR_IDLE;
      hold_r <= '0;
    end else if (ce) begin
      case (wst_r)
        WR_IDLE:   if (wr_go) begin
          hold_r <= cur;
          wst_r  <= WR_WORD1;
        end
        WR_WORD1:  wst_r <= WR_COMMIT;
        WR_COMMIT: wst_r <= WR_IDLE;
        default:   wst_r <= WR_IDLE;
      endcase
    end
  end

  // Put moves only after the second word is on the port
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      put_r  <= '0;
      get_r  <= '0;
      fill_r <= '0;
    end else if (ce) begin
      if (commit)
        put_r <= (put_r + 5'h01 == ring_len[4:0] || put_r == 5'h1F)
                 ? 5'h00 : put_r + 5'h01;
      if (ack)
        get_r <= (get_r + 5'h01 == ring_len[4:0] || get_r == 5'h1F)
                 ? 5'h00 : get_r + 5'h01;
      if (commit && !ack) fill_r <= fill_r + 6'h01;
      if (ack && !commit) fill_r <= fill_r - 6'h01;
    end
  end

  // Lost report when the source ignores back-pressure; set beats clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) drop_r <= 1'b0;
    else if (ce) begin
      if (tx_done && !buf_ready) drop_r <= 1'b1;
      else if (reg_wr && reg_addr == REG_EVT_STATE &&
               reg_wdata[ST_DROP_BIT]) drop_r <= 1'b0;
    end
  end

  // ==========================================================
  // Standard filter list scanner
  ctxe_sst_type sst_r;
  logic [6:0]   sidx_r;
  logic [10:0]  sid_r;
  logic         scan_issue;
  ctxe_flt_type fel;
  logic         last_el;

  assign scan_issue = ce && (sst_r == SC_READ) && (wst_r == WR_IDLE) &&
                      !wr_go;
  assign fel     = flt_dec(ram_rdata);
  assign last_el = ({1'b0, sidx_r} + 8'h01) >= flt_len;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sst_r       <= SC_IDLE;
      sidx_r      <= '0;
      sid_r       <= '0;
      scan_done   <= 1'b0;
      scan_hit    <= 1'b0;
      scan_index  <= '0;
      scan_action <= '0;
    end else if (ce) begin
      scan_done <= 1'b0;
      case (sst_r)
        SC_IDLE: if (scan_start) begin
          sid_r  <= scan_id;
          sidx_r <= '0;
          if (flt_len == '0) begin
            scan_done <= 1'b1;
            scan_hit  <= 1'b0;
          end else begin
            sst_r <= SC_READ;
          end
        end
        SC_READ: if (scan_issue) sst_r <= SC_WAIT;
        SC_WAIT: sst_r <= SC_EVAL;
        SC_EVAL: begin
          if (flt_hit(fel, sid_r) || last_el) begin
            scan_done   <= 1'b1;
            scan_hit    <= flt_hit(fel, sid_r);
            scan_index  <= sidx_r;
            scan_action <= fel.action;
            sst_r       <= SC_IDLE;
          end else begin
            sidx_r <= sidx_r + 7'h01;
            sst_r  <= SC_READ;
          end
        end
        default: sst_r <= SC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Message RAM port; writer has priority over the scanner
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ram_addr  <= '0;
      ram_wdata <= '0;
      ram_we    <= 1'b0;
      ram_re    <= 1'b0;
    end else if (ce) begin
      ram_we <= 1'b0;
      ram_re <= 1'b0;
      if (wr_go) begin
        ram_we    <= 1'b1;
        ram_addr  <= evt_base_r + RAM_AW'({put_r, 1'b0});
        ram_wdata <= word0(cur);
      end else if (wst_r == WR_WORD1) begin
        ram_we    <= 1'b1;
        ram_addr  <= evt_base_r + RAM_AW'({put_r, 1'b1});
        ram_wdata <= word1(hold_r, no_rt_r);
      end else if (scan_issue) begin
        ram_re   <= 1'b1;
        ram_addr <= flt_base_r + RAM_AW'(sidx_r);
      end
    end
  end

  // ==========================================================
  // Register read port; data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_n) reg_rdata <= '0;
    else if (ce) begin
      reg_rdata <= '0;
      if (reg_rd) begin
        case (reg_addr)
          REG_EVT_CFG:
            reg_rdata <= {10'h000, evt_size_r, 16'(evt_base_r)};
          REG_EVT_STATE: begin
            reg_rdata[5:0]              <= fill_r;
            reg_rdata[ST_GET_LSB +: 5]  <= get_r;
            reg_rdata[ST_PUT_LSB +: 5]  <= put_r;
            reg_rdata[ST_FULL_BIT]      <= !ring_room;
            reg_rdata[ST_DROP_BIT]      <= drop_r;
          end
          REG_FLT_CFG:
            reg_rdata <= {8'h00, flt_size_r, 16'(flt_base_r)};
          REG_CTRL: reg_rdata[CTRL_NORT_BIT] <= no_rt_r;
          REG_SCAN: begin
            reg_rdata[6:0]                <= scan_index;
            reg_rdata[SCAN_ACT_LSB +: 3]  <= scan_action;
            reg_rdata[SCAN_HIT_BIT]       <= scan_hit;
            reg_rdata[SCAN_BUSY_BIT]      <= (sst_r != SC_IDLE);
          end
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_order_put: assert property (commit && ce |=>
    put_r == (($past(put_r) + 5'h01 == $past(ring_len[4:0]))
              ? 5'h00 : $past(put_r) + 5'h01))
    else $error("put index did not advance by one");
  a_esi_bit: assert property (wr_go |=> ram_we &&
    ram_wdata[W0_ESI_BIT] == $past(cur.evt.err_passive))
    else $error("error state bit wrong in word0");
  a_xtd_rtr: assert property (wr_go |=>
    ram_wdata[W0_XTD_BIT] == $past(cur.evt.extended_id_flag) &&
    ram_wdata[W0_RTR_BIT] == $past(cur.evt.remote_request_flag))
    else $error("format bits wrong in word0");
  a_std_align: assert property (wr_go && !cur.evt.extended_id_flag |=>
    ram_wdata[28:STD_ID_LSB] == $past(cur.evt.id[10:0]) &&
    ram_wdata[STD_ID_LSB-1:0] == '0)
    else $error("standard id not left aligned");
  a_tag_copy: assert property (wr_go |-> ##2 ram_we &&
    ram_wdata[W1_TAG_LSB +: 8] == $past(cur.evt.tag, 2))
    else $error("tag not copied into word1");
  a_kind_nort: assert property (wr_go && no_rt_r && ce ##1 ce |->
    ##1 ram_wdata[W1_KIND_LSB +: 2] == KIND_CANCEL)
    else $error("kind must be cancel code without retransmit");
  a_stamp_copy: assert property (wr_go |-> ##2
    ram_wdata[15:0] == $past(cur.stamp, 2))
    else $error("stamp missing from word1");
  a_record_whole: assert property ($changed(put_r) |->
    $past(ram_we) && $past(ram_we, 2))
    else $error("put moved before both words were written");
  a_scan_stop: assert property (scan_done && scan_hit |->
    scan_action != FA_OFF)
    else $error("scan stopped on a disabled element");
  a_flt_addr: assert property (ram_re |->
    ram_addr == flt_base_r + RAM_AW'(sidx_r))
    else $error("filter element address wrong");

  c_record: cover property (wr_go ##1 1'b1 ##1 commit);
  c_scan_hit: cover property (scan_done && scan_hit);
  c_scan_miss: cover property (scan_done && !scan_hit);
  c_ring_full: cover property (buf_valid && !ring_room);

endmodule : ctxe_writer

`default_nettype wire

// *** common/ctxe_pkg.sv ***
package ctxe_pkg;

  // ==========================================================
  // Register offsets (byte addresses on the plain register port)
  localparam logic [7:0] REG_EVT_CFG   = 8'h00;
  localparam logic [7:0] REG_EVT_STATE = 8'h04;
  localparam logic [7:0] REG_EVT_ACK   = 8'h08;
  localparam logic [7:0] REG_FLT_CFG   = 8'h0C;
  localparam logic [7:0] REG_CTRL      = 8'h10;
  localparam logic [7:0] REG_SCAN      = 8'h14;

  // ==========================================================
  // Register field positions
  localparam int EVT_SIZE_LSB   = 16;
  localparam int FLT_SIZE_LSB   = 16;
  localparam int ST_GET_LSB     = 8;
  localparam int ST_PUT_LSB     = 16;
  localparam int ST_FULL_BIT    = 24;
  localparam int ST_DROP_BIT    = 25;
  localparam int CTRL_NORT_BIT  = 0;
  localparam int ACK_BIT        = 0;
  localparam int SCAN_ACT_LSB   = 8;
  localparam int SCAN_HIT_BIT   = 16;
  localparam int SCAN_BUSY_BIT  = 17;

  // ==========================================================
  // Event record layout
  localparam int W0_ESI_BIT   = 31;
  localparam int W0_XTD_BIT   = 30;
  localparam int W0_RTR_BIT   = 29;
  localparam int STD_ID_LSB   = 18;
  localparam int W1_TAG_LSB   = 24;
  localparam int W1_KIND_LSB  = 22;
  localparam int W1_FD_BIT    = 21;
  localparam int W1_BRS_BIT   = 20;
  localparam int W1_DLC_LSB   = 16;
  localparam logic [1:0] KIND_TX     = 2'h1;
  localparam logic [1:0] KIND_CANCEL = 2'h2;

  // ==========================================================
  // Standard filter element coding
  localparam int FLT_MAX = 128;
  localparam logic [1:0] FT_RANGE   = 2'h0;
  localparam logic [1:0] FT_DUAL    = 2'h1;
  localparam logic [1:0] FT_CLASSIC = 2'h2;
  localparam logic [2:0] FA_OFF     = 3'h0;
  localparam logic [2:0] FA_DEDIC   = 3'h7;

  // Transmit completion report from the protocol engine
  typedef struct packed {
    logic        err_passive;
    logic        extended_id_flag;
    logic        remote_request_flag;
    logic [28:0] id;
    logic [7:0]  tag;
    logic        cancel;
    logic        fd;
    logic        rate_switch_flag;
    logic [3:0]  dlc;
  } ctxe_evt_type;

  // Report plus stamp taken at start of frame
  typedef struct packed {
    ctxe_evt_type evt;
    logic [15:0]  stamp;
  } ctxe_rec_type;

  // Decoded standard filter element
  typedef struct packed {
    logic [1:0]  ftype;
    logic [2:0]  action;
    logic [10:0] id_a;
    logic [10:0] id_b;
  } ctxe_flt_type;

endpackage : ctxe_pkg

// *** test/ctxe_ram_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Message RAM seen by the writer and by the host
module ctxe_ram_model #(
  parameter int RAM_AW = 16
) (
  input  wire logic              ref_clk,
  input  wire logic [RAM_AW-1:0] ram_addr,
  input  wire logic [31:0]       ram_wdata,
  input  wire logic              ram_we,
  input  wire logic              ram_re,
  output logic [31:0]            ram_rdata
);
  logic [31:0] mem [0:255];

  initial ram_rdata = 32'h0;

  // Word access at base plus index; idle bus toggles, no stale value
  always @(posedge ref_clk) begin
    if (ram_we) mem[ram_addr[7:0]] <= ram_wdata;
    if (ram_re) ram_rdata <= mem[ram_addr[7:0]];
    else ram_rdata <= ~ram_rdata;
  end
endmodule : ctxe_ram_model

`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb;
  import ctxe_pkg::*;

  typedef struct packed {
    ctxe_evt_type evt;
    logic [15:0]  stamp;
    logic [31:0]  w0;
    logic [31:0]  w1;
  } ctxe_row_type;

  logic ref_clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, ram_wdata, rd;
  logic reg_wr = 1'b0, reg_rd = 1'b0, tx_sof = 1'b0, tx_done = 1'b0;
  logic [15:0] stamp_value = 16'h0, ram_addr;
  ctxe_evt_type tx_evt = '0;
  logic tx_evt_ready, scan_start = 1'b0, scan_done, scan_hit;
  logic [10:0] scan_id = 11'h0;
  logic [6:0] scan_index;
  logic [2:0] scan_action;
  logic ram_we, ram_re;
  logic [31:0] ram_rdata;
  int fails = 0, n_tests = 0;

  // Ordinary records: inputs, stamp, expected word 0 and word 1
  ctxe_row_type rows [4] = '{
    '{'{1'b1,1'b0,1'b1,29'h123,8'hA5,1'b0,1'b0,1'b0,4'hF},
      16'h1234,32'hA48C0000,32'hA54F1234},
    '{'{1'b0,1'b1,1'b0,29'h1ABCDEF0,8'h3C,1'b1,1'b1,1'b1,4'h9},
      16'hFFFF,32'h5ABCDEF0,32'h3CB9FFFF},
    '{'{1'b0,1'b0,1'b0,29'h7FF,8'h00,1'b0,1'b1,1'b0,4'h8},
      16'h0001,32'h1FFC0000,32'h00680001},
    '{'{1'b1,1'b1,1'b1,29'h1,8'hFF,1'b0,1'b0,1'b1,4'h0},
      16'h8000,32'hE0000001,32'hFF508000}};

  always #12.5 ref_clk = ~ref_clk;

  ctxe_writer dut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_sof(tx_sof),
    .stamp_value(stamp_value), .tx_done(tx_done), .tx_evt(tx_evt),
    .tx_evt_ready(tx_evt_ready), .scan_start(scan_start),
    .scan_id(scan_id), .scan_done(scan_done), .scan_hit(scan_hit),
    .scan_index(scan_index), .scan_action(scan_action),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_we(ram_we),
    .ram_re(ram_re), .ram_rdata(ram_rdata));

  ctxe_ram_model ram (.ref_clk(ref_clk), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_we(ram_we), .ram_re(ram_re),
    .ram_rdata(ram_rdata));

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : rd_reg

  task automatic push(input ctxe_row_type r);
    @(posedge ref_clk);
    tx_sof <= 1'b1; stamp_value <= r.stamp;
    @(posedge ref_clk);
    tx_sof <= 1'b0; stamp_value <= ~r.stamp;
    tx_done <= 1'b1; tx_evt <= r.evt;
    // Ready as it stands at the edge that takes the report
    #1;
    chk({31'h0, tx_evt_ready}, 32'h1);
    @(posedge ref_clk);
    tx_done <= 1'b0;
  endtask : push

  task automatic scan(input logic [10:0] id, input logic [31:0] e);
    @(posedge ref_clk);
    scan_start <= 1'b1; scan_id <= id;
    @(posedge ref_clk);
    scan_start <= 1'b0;
    for (int i = 0; i < 100 && scan_done !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk({31'h0, scan_done}, 32'h1);
    // Bit 11 of the expectation marks a hit with index and action
    if (e[11]) chk({20'h0, 1'b1, scan_hit, scan_index, scan_action}, e);
    else chk({31'h0, scan_hit}, 32'h0);
  endtask : scan

  task automatic finish_test;
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // Hang guard, far beyond the under two hundred cycles needed
  initial begin
    #(25 * 5000);
    fails++;
    finish_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    ram.mem[8'h80] = 32'h000007FF;  // disabled range element
    ram.mem[8'h81] = 32'h99000700;  // classic, reject
    ram.mem[8'h82] = 32'h495500AA;  // dual, fifo 0
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    // Ring of size 0 has no room, so it reads as full
    rd_reg(REG_EVT_STATE); chk(rd, 32'h01000000);
    rd_reg(8'hFC); chk(rd, 32'h0);
    wr(REG_EVT_CFG, 32'h00040010);
    foreach (rows[i]) push(rows[i]);
    repeat (30) @(posedge ref_clk);
    foreach (rows[i]) begin
      chk(ram.mem[16 + 2 * i], rows[i].w0);
      chk(ram.mem[17 + 2 * i], rows[i].w1);
    end
    // Ring full: fill 4, put wrapped to 0
    rd_reg(REG_EVT_STATE); chk(rd, 32'h01000004);
    // Record held back while the ring is full, written after one release
    wr(REG_CTRL, 32'h1);
    push(rows[2]);
    repeat (10) @(posedge ref_clk);
    rd_reg(REG_EVT_STATE); chk(rd, 32'h01000004);
    chk(ram.mem[17], rows[0].w1);
    wr(REG_EVT_ACK, 32'h1);
    repeat (30) @(posedge ref_clk);
    chk(ram.mem[17], 32'h00A80001);
    rd_reg(REG_EVT_STATE); chk(rd, 32'h01010104);
    // Filter list of three elements at word 0x80
    wr(REG_FLT_CFG, 32'h00030080);
    scan(11'h155, 32'h00000C0B);
    scan(11'h0AA, 32'h00000C11);
    scan(11'h300, 32'h0);
    // Miss reports the last element: index 2, action 001, not busy
    rd_reg(REG_SCAN); chk(rd, 32'h00000102);
    rd_reg(REG_FLT_CFG); chk(rd, 32'h00030080);
    // Mid-run reset clears ring state and mode
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_reg(REG_EVT_STATE); chk(rd, 32'h01000000);
    // Write while the clock enable is low must be ignored
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(REG_CTRL, 32'h1);
    ce <= 1'b1;
    rd_reg(REG_CTRL); chk(rd, 32'h0);
    finish_test();
  end
endmodule : tb

`default_nettype wire
